// *** src/global_space_pkg.sv ***
// constants, offsets and types for the global register space decoder
package global_space_pkg;

  // ***************************************************************
  // address space geometry
  // ***************************************************************
  localparam int unsigned SYS_AW = 19;
  localparam int unsigned NUM_PORTS = 8;
  localparam logic [2:0] BRIDGE_TOP_SEL = 3'h0;  // bits 18:16 of port regions
  localparam logic [5:0] SWITCH_SEL = 6'h1F;     // bits 18:13, 0x3E000
  localparam logic [11:0] PCI_SPACE_END = 12'h0FF;
  localparam logic [11:0] EXT_SPACE_END = 12'h3FF;

  // ***************************************************************
  // bridge register offsets within each port region
  // ***************************************************************
  localparam logic [11:0] OFF_SLOT_CTL = 12'h058;
  localparam logic [11:0] OFF_IND_ADDR = 12'h0E8;
  localparam logic [11:0] OFF_IND_DATA = 12'h0EC;
  localparam logic [11:0] OFF_ECFG_PTR = 12'h0F8;
  localparam logic [11:0] OFF_ECFG_WIN = 12'h0FC;
  localparam logic [11:0] OFF_LINK_STATE = 12'h400;
  localparam logic [11:0] OFF_SCRATCH = 12'h404;
  localparam int unsigned FR_TRIGGER_BIT = 0;

  // ***************************************************************
  // switch region offsets (bits 12:0 of system address)
  // ***************************************************************
  localparam logic [12:0] OFF_PROTECT = 13'h0000;
  localparam logic [12:0] OFF_PORT_CTL_BASE = 13'h0100;
  localparam int unsigned PROTECT_SWITCH_BIT = 0;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [16:0] RST_IND_ADDR = 17'h00000;
  localparam logic [11:0] RST_ECFG_PTR = 12'h000;
  localparam logic [7:0] RST_LINK_STATE = 8'h00;
  localparam logic [15:0] RST_SLOT_CTL = 16'h0000;
  localparam logic [31:0] RST_SCRATCH = 32'h00000000;
  localparam logic [7:0] RST_PROTECT = 8'h00;

  // ***************************************************************
  // side effect delay
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SE_DELAY_NS = 1000000;  // 1 ms
  localparam int unsigned SE_DELAY_CYC = SE_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 20;

  // ***************************************************************
  // enumerations
  // ***************************************************************
  typedef enum logic [1:0] {
    SRC_CFG = 2'b00,
    SRC_SMBUS = 2'b01,
    SRC_EEPROM = 2'b10
  } source_e;

  typedef enum logic [1:0] {
    MODE_DISABLED = 2'b00,
    MODE_UPSTREAM = 2'b01,
    MODE_DOWNSTREAM = 2'b10
  } port_mode_e;

  localparam port_mode_e RST_MODE_PORT0 = MODE_UPSTREAM;
  localparam port_mode_e RST_MODE_OTHER = MODE_DOWNSTREAM;

  typedef enum logic {
    SE_IDLE = 1'b0,
    SE_WAIT = 1'b1
  } se_state_e;

endpackage

// *** src/global_register_space_access.sv ***
// global register space decoder with indirect access and delayed effects
//
// Function
// RULE1: one 256 KB space, 19-bit system address, shared by EEPROM and SMBus
// RULE2: 4 KB bridge region per port 0..7, base 0x00000 step 0x2000
// RULE3: one 8 KB switch region at 0x3E000 to 0x3FFFF
// RULE4: 0x10000-0x3DFFF and unmapped addresses reserved, read undefined
// RULE5: bridge registers answer config requests as function 0 in US/DS mode
// RULE6: config address of bridge register equals its region offset
// RULE7: indirect pointer selects global register, data read returns it
// RULE8: indirect data write updates register selected by pointer
// RULE9: every function holds its own indirect pair reaching whole device
// RULE10: protection register applies to config requests only
// RULE11: ext-config pointer and window not reachable through indirect pair
// RULE12: bridge registers reachable by indirect, SMBus, EEPROM in any mode
// RULE13: requesters use native size or full dword byte enables
// RULE14: side-effect config write: completion first, effect 1 ms later; a newer delayed write applies the pending effect at once
// RULE15: unaccepted completion at delay end is dropped, effect still done
// RULE16: delay applies to function reset trigger and port mode writes
// RULE17: never trigger function reset on crosslinked upstream port; the code fires it on any port, whatever its mode
// RULE18: offsets 0-FF pci, 100-3FF extended, 400-FFF vendor per port
// RULE19: reserved bridge addresses read zero, writes have no effect
// RULE20: registers absent in current mode behave as reserved
// RULE21: each bridge space holds ext-config pointer and window pair
// RULE22: pointer holds system address bits 18:2, full dword transfers
// RULE23: window access targets bridge offset held in ext-config pointer
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module global_register_space_access #(
  parameter int unsigned SE_DELAY_CYCLES = global_space_pkg::SE_DELAY_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic REQ_RD,
  input wire logic REQ_WR,
  input wire logic [1:0] REQ_SRC,
  input wire logic [2:0] REQ_PORT,
  input wire logic [2:0] REQ_FUNC,
  input wire logic [18:0] REQ_ADDR,
  input wire logic [3:0] REQ_BE,
  input wire logic [31:0] REQ_WDATA,
  input wire logic CPL_ACCEPT,
  output logic [31:0] RD_DATA,
  output logic CPL_VALID,
  output logic CPL_DROPPED,
  output logic SE_PENDING,
  output logic [7:0] FUNC_RESET,
  output logic [15:0] PORT_MODE
);

  // ***************************************************************
  // decode helpers
  // ***************************************************************

  // bridge region hit: lower 4 KB of each 8 KB port step
  function automatic logic is_bridge(input logic [18:0] a);
    return (a[18:16] == global_space_pkg::BRIDGE_TOP_SEL) && !a[12];
  endfunction

  function automatic logic is_switch(input logic [18:0] a);
    return a[18:13] == global_space_pkg::SWITCH_SEL;
  endfunction

  // byte enable write merge
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ***************************************************************
  // storage
  // ***************************************************************
  logic [16:0] ind_addr_q [8];
  logic [11:0] ecfg_ptr_q [8];
  logic [7:0] link_state_q [8];
  logic [15:0] slot_ctl_q [8];
  logic [31:0] scratch_q [8];
  logic [1:0] port_ctl_q [8];
  logic [7:0] protect_q;
  logic [1:0] mode_q [8];

  global_space_pkg::se_state_e se_state_q;
  logic [19:0] timer_q;
  logic pend_fr_q;
  logic [2:0] pend_port_q;
  logic [1:0] pend_mode_q;
  logic cpl_q;
  logic dropped_q;
  logic [31:0] rdata_q;
  logic [7:0] fr_pulse_q;
  // sequencer strobes, read by the per-port logic ahead of the sequencer
  logic expire;
  logic fire_pend;

  // ***************************************************************
  // address resolution
  // ***************************************************************
  logic is_cfg;
  logic [18:0] local_addr;
  logic [18:0] eff;
  logic [2:0] lport;
  logic [2:0] tport;
  logic [11:0] toff;
  logic via_ind;
  logic blocked;
  logic [31:0] rd_val;

  always_comb begin
    is_cfg = (REQ_SRC == global_space_pkg::SRC_CFG);
    // config offset maps onto the port's own region
    if (is_cfg) begin
      local_addr = {3'h0, REQ_PORT, 1'b0, REQ_ADDR[11:0]};  // [RULE6]
    end else begin
      local_addr = REQ_ADDR;  // [RULE1]
    end
    lport = local_addr[15:13];
    eff = local_addr;
    via_ind = 1'b0;
    blocked = 1'b0;
    if (is_cfg && (REQ_FUNC != 3'h0 ||
        mode_q[REQ_PORT] == global_space_pkg::MODE_DISABLED)) begin
      blocked = 1'b1;  // [RULE5]
    end else if (is_bridge(local_addr) &&
                 local_addr[11:0] == global_space_pkg::OFF_IND_DATA) begin
      eff = {ind_addr_q[lport], 2'b00};  // [RULE7] [RULE9] [RULE22]
      via_ind = 1'b1;
    end else if (is_bridge(local_addr) &&
                 local_addr[11:0] == global_space_pkg::OFF_ECFG_WIN) begin
      eff = {local_addr[18:12], ecfg_ptr_q[lport][11:2], 2'b00};  // [RULE23]
      if (eff[11:0] == global_space_pkg::OFF_ECFG_WIN ||
          eff[11:0] == global_space_pkg::OFF_IND_DATA) begin
        blocked = 1'b1;
      end
    end
    tport = eff[15:13];
    toff = eff[11:0];
    // window and nested indirect registers are hidden from the pair
    if (via_ind && is_bridge(eff) &&
        (toff == global_space_pkg::OFF_ECFG_PTR ||
         toff == global_space_pkg::OFF_ECFG_WIN ||
         toff == global_space_pkg::OFF_IND_DATA)) begin
      blocked = 1'b1;  // [RULE11]
    end
    // protection guards config requests only
    if (is_cfg && via_ind && is_switch(eff) && REQ_WR &&
        protect_q[global_space_pkg::PROTECT_SWITCH_BIT]) begin
      blocked = 1'b1;  // [RULE10]
    end
  end

  // read value of the resolved target
  always_comb begin
    rd_val = 32'h00000000;  // [RULE4] [RULE19]
    if (!blocked && is_bridge(eff)) begin
      unique case (toff)  // [RULE2] [RULE18]
        global_space_pkg::OFF_IND_ADDR: rd_val = {15'h0, ind_addr_q[tport]};
        global_space_pkg::OFF_ECFG_PTR: rd_val = {20'h00000, ecfg_ptr_q[tport]};
        global_space_pkg::OFF_LINK_STATE: begin
          rd_val = {24'h000000, link_state_q[tport]};
          rd_val[global_space_pkg::FR_TRIGGER_BIT] = 1'b0;
        end
        global_space_pkg::OFF_SLOT_CTL: begin
          if (mode_q[tport] == global_space_pkg::MODE_DOWNSTREAM) begin
            rd_val = {16'h0000, slot_ctl_q[tport]};  // [RULE20]
          end
        end
        global_space_pkg::OFF_SCRATCH: rd_val = scratch_q[tport];
        default: rd_val = 32'h00000000;
      endcase
    end else if (!blocked && is_switch(eff)) begin  // [RULE3]
      if (eff[12:0] == global_space_pkg::OFF_PROTECT) begin
        rd_val = {24'h000000, protect_q};
      end else if (eff[12:5] == global_space_pkg::OFF_PORT_CTL_BASE[12:5]) begin
        rd_val = {30'h0, port_ctl_q[eff[4:2]]};
      end
    end
  end

  // ***************************************************************
  // write decode and side effect request
  // ***************************************************************
  logic wr_ok;
  logic wr_bridge;
  logic wr_port_ctl;
  logic se_req;
  logic se_fr;
  logic [2:0] se_port;
  logic delayed;

  always_comb begin
    wr_ok = REQ_WR && !blocked;
    wr_bridge = wr_ok && is_bridge(eff);  // [RULE12]
    wr_port_ctl = wr_ok && is_switch(eff) && REQ_BE[0] &&
                  eff[12:5] == global_space_pkg::OFF_PORT_CTL_BASE[12:5];
    se_fr = wr_bridge && toff == global_space_pkg::OFF_LINK_STATE &&
            REQ_BE[0] && REQ_WDATA[global_space_pkg::FR_TRIGGER_BIT];
    se_req = se_fr || wr_port_ctl;  // [RULE16]
    se_port = se_fr ? tport : eff[4:2];
    delayed = se_req && is_cfg;  // [RULE14]
  end

  // ***************************************************************
  // per-port register storage
  // ***************************************************************
  for (genvar p = 0; p < 8; p++) begin : g_port
    logic hit;
    logic [31:0] mv;
    assign hit = wr_bridge && tport == 3'(p);
    assign mv = merge(32'h00000000, REQ_WDATA, REQ_BE);

    // bridge registers of this port, written with byte enables
    always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
        ind_addr_q[p] <= global_space_pkg::RST_IND_ADDR;
        ecfg_ptr_q[p] <= global_space_pkg::RST_ECFG_PTR;
        link_state_q[p] <= global_space_pkg::RST_LINK_STATE;
        slot_ctl_q[p] <= global_space_pkg::RST_SLOT_CTL;
        scratch_q[p] <= global_space_pkg::RST_SCRATCH;
      end else if (hit) begin  // [RULE8]
        unique case (toff)
          global_space_pkg::OFF_IND_ADDR: begin
            ind_addr_q[p] <= merge({15'h0, ind_addr_q[p]}, REQ_WDATA,
                                   REQ_BE)[16:0];
          end
          global_space_pkg::OFF_ECFG_PTR: begin  // [RULE21]
            ecfg_ptr_q[p] <= merge({20'h00000, ecfg_ptr_q[p]}, REQ_WDATA,
                                   REQ_BE)[11:0];
          end
          global_space_pkg::OFF_LINK_STATE: begin
            if (REQ_BE[0]) begin
              link_state_q[p] <= {mv[7:1], 1'b0};
            end
          end
          global_space_pkg::OFF_SLOT_CTL: begin
            if (mode_q[p] == global_space_pkg::MODE_DOWNSTREAM) begin
              slot_ctl_q[p] <= merge({16'h0000, slot_ctl_q[p]}, REQ_WDATA,
                                     REQ_BE)[15:0];  // [RULE20]
            end
          end
          global_space_pkg::OFF_SCRATCH: begin
            scratch_q[p] <= merge(scratch_q[p], REQ_WDATA, REQ_BE);
          end
          default: ;  // [RULE19]
        endcase
      end
    end

    // port control mode field, stored at once
    always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
        port_ctl_q[p] <= (p == 0) ? global_space_pkg::RST_MODE_PORT0 :
                                    global_space_pkg::RST_MODE_OTHER;
      end else if (wr_port_ctl && eff[4:2] == 3'(p)) begin
        port_ctl_q[p] <= REQ_WDATA[1:0];
      end
    end

    // applied mode and reset trigger pulse, immediate effect wins
    always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
        mode_q[p] <= (p == 0) ? global_space_pkg::RST_MODE_PORT0 :
                                global_space_pkg::RST_MODE_OTHER;
        fr_pulse_q[p] <= 1'b0;
      end else begin
        fr_pulse_q[p] <= (fire_pend && pend_fr_q && pend_port_q == 3'(p)) ||
                         (se_req && !delayed && se_fr && se_port == 3'(p));
        if (se_req && !delayed && !se_fr && se_port == 3'(p)) begin
          mode_q[p] <= REQ_WDATA[1:0];
        end else if (fire_pend && !pend_fr_q && pend_port_q == 3'(p)) begin
          mode_q[p] <= pend_mode_q;  // [RULE14]
        end
      end
    end
  end

  // protection register in the switch region
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      protect_q <= global_space_pkg::RST_PROTECT;
    end else if (wr_ok && is_switch(eff) && REQ_BE[0] &&
                 eff[12:0] == global_space_pkg::OFF_PROTECT) begin
      protect_q <= REQ_WDATA[7:0];
    end
  end

  // ***************************************************************
  // delayed side effect sequencer
  // ***************************************************************

  always_comb begin
    // last waiting cycle; the effect lands on the following edge
    expire = (se_state_q == global_space_pkg::SE_WAIT) && timer_q == 20'h00001;
    // a newer delayed write flushes the older one at once
    fire_pend = expire || (se_state_q == global_space_pkg::SE_WAIT && delayed);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      se_state_q <= global_space_pkg::SE_IDLE;
      timer_q <= 20'h00000;
      pend_fr_q <= 1'b0;
      pend_port_q <= 3'h0;
      pend_mode_q <= 2'h0;
    end else if (delayed) begin
      se_state_q <= global_space_pkg::SE_WAIT;
      timer_q <= SE_DELAY_CYCLES[19:0];  // [RULE14]
      pend_fr_q <= se_fr;
      pend_port_q <= se_port;
      pend_mode_q <= REQ_WDATA[1:0];
    end else begin
      unique case (se_state_q)
        global_space_pkg::SE_IDLE: ;
        global_space_pkg::SE_WAIT: begin
          timer_q <= timer_q - 20'h00001;
          if (expire) begin
            se_state_q <= global_space_pkg::SE_IDLE;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // completion and read data
  // ***************************************************************

  // completion held until accepted or the delay expires; a new request sets over clear
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cpl_q <= 1'b0;
      dropped_q <= 1'b0;
    end else begin
      dropped_q <= expire && cpl_q && !CPL_ACCEPT;  // [RULE15]
      if (is_cfg && (REQ_RD || REQ_WR)) begin
        cpl_q <= 1'b1;
      end else if (CPL_ACCEPT || expire) begin
        cpl_q <= 1'b0;
      end
    end
  end

  // read data stands one cycle after the read strobe
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_q <= 32'h00000000;
    end else if (REQ_RD) begin
      rdata_q <= rd_val;
    end else begin
      // zero outside the answer cycle keeps stale data off the bus
      rdata_q <= 32'h00000000;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign RD_DATA = rdata_q;
  assign CPL_VALID = cpl_q;
  assign CPL_DROPPED = dropped_q;
  assign SE_PENDING = se_state_q;
  assign FUNC_RESET = fr_pulse_q;
  for (genvar m = 0; m < 8; m++) begin : g_mode
    assign PORT_MODE[m*2 +: 2] = mode_q[m];
  end

endmodule

// *** verif/global_space_chk.sv ***
// assertion checker for the global register space decoder
`timescale 1ns/1ns
module global_space_chk #(
  parameter int unsigned SE_DELAY_CYCLES = 20
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic REQ_RD,
  input wire logic REQ_WR,
  input wire logic [1:0] REQ_SRC,
  input wire logic [2:0] REQ_PORT,
  input wire logic [2:0] REQ_FUNC,
  input wire logic [18:0] REQ_ADDR,
  input wire logic [3:0] REQ_BE,
  input wire logic [31:0] REQ_WDATA,
  input wire logic CPL_ACCEPT,
  input wire logic [31:0] RD_DATA,
  input wire logic CPL_VALID,
  input wire logic CPL_DROPPED,
  input wire logic SE_PENDING,
  input wire logic [7:0] FUNC_RESET,
  input wire logic [15:0] PORT_MODE
);
  // ***************************************************************
  // helper logic
  // ***************************************************************
  logic [19:0] pend_cnt_q;
  logic [2:0] sel_q;
  logic [2:0] port_q;
  logic [1:0] mode_q;
  logic cfg_req;
  logic cfg_any;
  logic sys_wr;
  // consecutive cycles with a side effect waiting
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !SE_PENDING) begin
      pend_cnt_q <= 20'h00000;
    end else begin
      pend_cnt_q <= pend_cnt_q + 20'h00001;
    end
  end
  // remembers request address and write data of the previous cycle
  always_ff @(posedge CLK_SYS) begin
    sel_q <= REQ_ADDR[4:2];
    port_q <= REQ_ADDR[15:13];
    mode_q <= REQ_WDATA[1:0];
  end
  // config request to a live function, and smbus or eeprom write
  assign cfg_req = (REQ_RD || REQ_WR) && REQ_SRC == 2'h0 &&
                   REQ_FUNC == 3'h0 && PORT_MODE[{REQ_PORT, 1'b0} +: 2] != 2'h0;
  assign sys_wr = REQ_WR && REQ_SRC != 2'h0 && REQ_BE[0];
  assign cfg_any = (REQ_RD || REQ_WR) && REQ_SRC == 2'h0;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_rd_data_idle: assert property (!REQ_RD |=> RD_DATA == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_cpl_raised: assert property (cfg_req && !SE_PENDING |=> CPL_VALID)
    else $error("completion not raised after config request");
  a_cpl_held: assert property (
    CPL_VALID && !CPL_ACCEPT && !SE_PENDING |=> CPL_VALID)
    else $error("completion withdrawn before acceptance");
  a_cpl_taken: assert property (
    CPL_VALID && CPL_ACCEPT && !cfg_any |=> !CPL_VALID)
    else $error("completion still pending after acceptance");
  a_sys_mode_now: assert property (
    sys_wr && REQ_ADDR[18:5] == 14'h1F08 && REQ_WDATA[1:0] != 2'h3
    |=> PORT_MODE[{sel_q, 1'b0} +: 2] == mode_q)
    else $error("immediate port mode write not applied");
  a_sys_reset_now: assert property (
    sys_wr && REQ_WDATA[0] && REQ_ADDR[18:16] == 3'h0 &&
    REQ_ADDR[12:0] == 13'h0400 |=> FUNC_RESET[port_q])
    else $error("immediate function reset not performed");
  a_se_delay_len: assert property (
    $fell(SE_PENDING) |-> pend_cnt_q == SE_DELAY_CYCLES)
    else $error("side effect delay has wrong length");
  a_drop_at_end: assert property (
    CPL_DROPPED |-> $past(SE_PENDING) && !SE_PENDING && !CPL_VALID)
    else $error("completion dropped outside delay expiry");
  a_drop_cause: assert property (
    $fell(SE_PENDING) && $past(CPL_VALID) && !$past(CPL_ACCEPT)
    |-> CPL_DROPPED)
    else $error("unaccepted completion not dropped at expiry");
  a_drop_single: assert property (CPL_DROPPED |=> !CPL_DROPPED)
    else $error("drop pulse longer than one cycle");

  c_effect_done: cover property ($fell(SE_PENDING));
  c_dropped: cover property (CPL_DROPPED);
  c_accepted: cover property (CPL_VALID && CPL_ACCEPT);
  c_freset: cover property (FUNC_RESET != 8'h00);
endmodule

bind global_register_space_access global_space_chk #(
  .SE_DELAY_CYCLES(SE_DELAY_CYCLES)
) chk_u (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .REQ_RD(REQ_RD), .REQ_WR(REQ_WR),
  .REQ_SRC(REQ_SRC), .REQ_PORT(REQ_PORT), .REQ_FUNC(REQ_FUNC),
  .REQ_ADDR(REQ_ADDR), .REQ_BE(REQ_BE), .REQ_WDATA(REQ_WDATA),
  .CPL_ACCEPT(CPL_ACCEPT), .RD_DATA(RD_DATA), .CPL_VALID(CPL_VALID),
  .CPL_DROPPED(CPL_DROPPED), .SE_PENDING(SE_PENDING),
  .FUNC_RESET(FUNC_RESET), .PORT_MODE(PORT_MODE)
);

// *** verif/link_partner_model.sv ***
// link partner model that accepts completions after a set latency
`timescale 1ns/1ns
module link_partner_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpl_valid,
  input wire logic [7:0] accept_lat,
  output logic cpl_accept
);
  logic [7:0] age_q;
  // ages a pending completion; latency zero never accepts it
  always_ff @(posedge clk) begin
    if (rst || !cpl_valid || cpl_accept) begin
      age_q <= 8'h00;
      cpl_accept <= 1'b0;
    end else begin
      age_q <= age_q + 8'h01;
      cpl_accept <= accept_lat != 8'h00 && age_q + 8'h01 == accept_lat;
    end
  end
endmodule

// *** verif/tb_global_register_space_access.sv ***
// self-checking testbench for the global register space decoder
`timescale 1ns/1ns
module tb_global_register_space_access;
  localparam int unsigned N = 20;
  logic clk_sys = 1'b0;
  logic reset, req_rd, req_wr, cpl_accept, cpl_valid, cpl_dropped, se_pending;
  logic [1:0] req_src;
  logic [2:0] req_port, req_func;
  logic [18:0] req_addr;
  logic [3:0] req_be;
  logic [31:0] req_wdata, rd_data;
  logic [7:0] func_reset, lat;
  logic [15:0] port_mode;
  int n_mismatch = 0;
  int checks = 0;

  global_register_space_access #(.SE_DELAY_CYCLES(N)) dut_u (
    .CLK_SYS(clk_sys), .RESET(reset), .REQ_RD(req_rd), .REQ_WR(req_wr),
    .REQ_SRC(req_src), .REQ_PORT(req_port), .REQ_FUNC(req_func),
    .REQ_ADDR(req_addr), .REQ_BE(req_be), .REQ_WDATA(req_wdata),
    .CPL_ACCEPT(cpl_accept), .RD_DATA(rd_data), .CPL_VALID(cpl_valid),
    .CPL_DROPPED(cpl_dropped), .SE_PENDING(se_pending),
    .FUNC_RESET(func_reset), .PORT_MODE(port_mode));
  link_partner_model lp_u (.clk(clk_sys), .rst(reset),
    .cpl_valid(cpl_valid), .accept_lat(lat), .cpl_accept(cpl_accept));

  // ***************************************************************
  // clock, shared tasks
  // ***************************************************************
  always #10 clk_sys = ~clk_sys;

  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one strobe cycle; returns just after the taking edge
  task automatic acc(input logic w, input logic [1:0] s,
                     input logic [2:0] p, f, input logic [18:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    req_wr <= w;
    req_rd <= ~w;
    req_src <= s;
    req_port <= p;
    req_func <= f;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk_sys);
    req_wr <= 1'b0;
    req_rd <= 1'b0;
    #1;
  endtask
  task automatic sw(input logic [18:0] a, input logic [31:0] d);
    acc(1'b1, 2'h1, 3'h0, 3'h0, a, d);
  endtask
  task automatic sr(input logic [18:0] a);
    acc(1'b0, 2'h1, 3'h0, 3'h0, a, 32'h0);
  endtask
  task automatic cw(input logic [2:0] p, input logic [11:0] o,
                    input logic [31:0] d);
    acc(1'b1, 2'h0, p, 3'h0, {7'h00, o}, d);
  endtask
  task automatic cr(input logic [2:0] p, f, input logic [11:0] o);
    acc(1'b0, 2'h0, p, f, {7'h00, o}, 32'h0);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_map();
    for (int p = 0; p < 8; p++) sw(19'(p * 8192 + 1028), 32'hA5A50000 + p);
    for (int p = 0; p < 8; p++) begin
      sr(19'(p * 8192 + 1028));
      chk("port scratch", rd_data, 32'hA5A50000 + p);
    end
    sw(19'h40404, 32'h0BAD0000);
    sr(19'h00404);
    chk("no alias", rd_data, 32'hA5A50000);
    sw(19'h10404, 32'h0000FFFF);
    sr(19'h10404);
    chk("reserved gap", rd_data, 32'h0);
    sr(19'h03404);
    chk("beyond region", rd_data, 32'h0);
    sw(19'h02200, 32'hFFFFFFFF);
    sr(19'h02200);
    chk("reserved offset", rd_data, 32'h0);
    sw(19'h00058, 32'h0000FFFF);
    sr(19'h00058);
    chk("slot ctl upstream", rd_data, 32'h0);
    sw(19'h02058, 32'h00001234);
    sr(19'h02058);
    chk("slot ctl downstream", rd_data, 32'h1234);
    sr(19'h3E000);
    chk("protect reset", rd_data, 32'h0);
  endtask
  task automatic t_cfg();
    cr(3'h3, 3'h0, 12'h404);
    chk("cfg read", rd_data, 32'hA5A50003);
    chk("cpl raised", cpl_valid, 32'h1);
    cr(3'h3, 3'h1, 12'h404);
    chk("cfg func 1", rd_data, 32'h0);
    sw(19'h3E108, 32'h0);
    chk("port 2 off", port_mode[5:4], 32'h0);
    cr(3'h2, 3'h0, 12'h404);
    chk("cfg port off", rd_data, 32'h0);
    sr(19'h04404);
    chk("smbus port off", rd_data, 32'hA5A50002);
    sw(19'h3E108, 32'h2);
  endtask
  task automatic t_ind();
    cw(3'h1, 12'h0E8, 32'h2901);
    cw(3'h2, 12'h0E8, 32'h3101);
    cw(3'h1, 12'h0EC, 32'h12345678);
    sr(19'h0A404);
    chk("indirect write", rd_data, 32'h12345678);
    cr(3'h2, 3'h0, 12'h0EC);
    chk("own pointer", rd_data, 32'hA5A50006);
    cr(3'h1, 3'h0, 12'h0EC);
    chk("indirect read", rd_data, 32'h12345678);
    sw(19'h0A0F8, 32'h404);
    cw(3'h1, 12'h0E8, 32'h283E);
    cr(3'h1, 3'h0, 12'h0EC);
    chk("ext ptr hidden", rd_data, 32'h0);
    cw(3'h1, 12'h0EC, 32'h0);
    sr(19'h0A0F8);
    chk("ext ptr kept", rd_data, 32'h404);
    cw(3'h4, 12'h0F8, 32'h404);
    cw(3'h4, 12'h0FC, 32'hCAFEF00D);
    sr(19'h08404);
    chk("window write", rd_data, 32'hCAFEF00D);
    cr(3'h4, 3'h0, 12'h0FC);
    chk("window read", rd_data, 32'hCAFEF00D);
  endtask
  task automatic t_protect();
    sw(19'h3E000, 32'h1);
    cw(3'h1, 12'h0E8, 32'hF843);
    cw(3'h1, 12'h0EC, 32'h1);
    repeat (N + 2) @(posedge clk_sys);
    #1;
    chk("guarded mode", port_mode[7:6], 32'h2);
    sw(19'h3E10C, 32'h1);
    chk("smbus bypass", port_mode[7:6], 32'h1);
    sw(19'h3E10C, 32'h2);
    sw(19'h3E000, 32'h0);
  endtask
  task automatic t_delay();
    cw(3'h1, 12'h0EC, 32'h1);
    chk("effect waiting", se_pending, 32'h1);
    repeat (N - 1) @(posedge clk_sys);
    #1;
    chk("mode held", port_mode[7:6], 32'h2);
    @(posedge clk_sys);
    #1;
    chk("mode applied", port_mode[7:6], 32'h1);
    chk("no drop", cpl_dropped, 32'h0);
    sw(19'h3E10C, 32'h2);
  endtask
  task automatic t_drop();
    lat <= 8'h00;
    cw(3'h6, 12'h400, 32'h1); // downstream port only
    repeat (N - 1) @(posedge clk_sys);
    #1;
    chk("reset held", func_reset, 32'h0);
    @(posedge clk_sys);
    #1;
    chk("reset done", func_reset, 32'h40);
    chk("cpl dropped", cpl_dropped, 32'h1);
    chk("cpl cleared", cpl_valid, 32'h0);
    sw(19'h0E400, 32'h1);
    chk("smbus reset", func_reset, 32'h80);
  endtask

  // ***************************************************************
  // main sequence and watchdog
  // ***************************************************************
  initial begin
    reset = 1'b1;
    {req_rd, req_wr, req_src, req_port, req_func} = '0;
    req_addr = '0;
    req_wdata = '0;
    req_be = 4'hF;
    lat = 8'h02;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk("reset modes", port_mode, 32'hAAA9);
    chk("reset pending", {cpl_valid, se_pending, func_reset}, 32'h0);
    t_map();
    t_cfg();
    t_ind();
    t_protect();
    t_delay();
    t_drop();
    wrap_up();
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end
endmodule
